// >>> verilog/fifo_defines.vh
// Constants shared by the dual-clock FIFO control logic.
// Assumes it is included by bare name in each design file that needs it.
`ifndef FIFO_DEFINES_VH
`define FIFO_DEFINES_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define DATA_W 36
`define PTR_W 17
`define ADDR_W 16
`define MEM_WORDS 65536
`define BLOCK_LOG 5'h0C
`define MAX_DEPTH_LOG 3'h4
`define MAX_WIDTH_CODE 3'h5

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_THRESH 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STAT 8'h0C
`define REG_IRQ_CLR 8'h10
`define REG_IRQ_EN 8'h14

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define CTRL_CLEAR 0
`define CTRL_PIPE 1
`define CTRL_WFALL 2
`define CTRL_RFALL 3
`define CTRL_WIDTH_LO 4
`define CTRL_WIDTH_HI 6
`define CTRL_DEPTH_LO 8
`define CTRL_DEPTH_HI 10
`define CTRL_RESET 32'h0000_0050
`define THRESH_RESET 32'h0000_0000
`define TH_AF_LO 0
`define TH_AF_HI 7
`define TH_AE_LO 8
`define TH_AE_HI 15

// ----------------------------------------
// Status and interrupt bits
// ----------------------------------------
`define ST_FULL 0
`define ST_EMPTY 1
`define ST_ALMOST_FULL_FLAG 2
`define ST_ALMOST_EMPTY_FLAG 3
`define ST_COUNT_LO 4
`define ST_COUNT_HI 20
`define IRQ_W 6
`define IRQ_FULL 0
`define IRQ_EMPTY 1
`define IRQ_ALMOST_FULL_FLAG 2
`define IRQ_ALMOST_EMPTY_FLAG 3
`define IRQ_WDROP 4
`define IRQ_RDROP 5

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// >>> verilog/sync_stage.v
// Two flip-flop synchroniser for a bus of independent levels or a gray word.
// Assumes the input changes at most one bit per change when used for words.
`timescale 1ns/1ps
`default_nettype none

module sync_stage #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);

  reg [W-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/clock_edge_tick.v
// Turns a foreign clock pin into a one-cycle tick on the system clock.
// Assumes the pin toggles slower than a quarter of the system clock rate.
`timescale 1ns/1ps
`default_nettype none

module clock_edge_tick (
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  input wire falling_i,
  output wire tick_o
);

  wire pin_s;
  reg pin_prev;

  sync_stage #(.W(1)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pin_i),
    .q_o(pin_s)
  );

  // Previous synchronised level for edge detection
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_s;
    end
  end

  // Selected edge: rising or falling
  assign tick_o = falling_i ? (pin_prev & ~pin_s) : (~pin_prev & pin_s);

endmodule

`default_nettype wire

// >>> verilog/dual_clock_fifo.v
// Dual-clock FIFO control over one embedded word memory, with AXI4-Lite control.
// Assumes write and read clocks arrive as pins slower than CLK_I / 4, with data
// and strobes held at least two CLK_I cycles either side of the active edge.
//
// Functional notes
// - Write and read clocks each have their own selectable active edge.
// - Write edge with write strobe stores the word and advances the write count.
// - Full is active high; writes while full are dropped; write count and contents stay.
// - Reads while empty are dropped; read count and contents stay.
// - Almost-full is active high, tripped by an 8-bit threshold held by the writer.
// - Almost-empty is active high, tripped by a separate 8-bit threshold.
// - Word width is 1, 2, 4, 9, 18 or 36 bits by arrangement.
// - Pipe control adds an extra output register stage to read data.
// - Clear empties the FIFO and forces full and almost-full low, empty and almost-empty high.
// - Depth and width settings fix word count, width and blocks cascaded.
// - Sixteen cascaded blocks at 1-bit width give a depth of 65,536 words.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defines.vh"

module dual_clock_fifo (
  input wire CLK_I,
  input wire RST_I,
  input wire [7:0] AWADDR_I,
  input wire AWVALID_I,
  output reg AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output reg WREADY_O,
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  input wire [7:0] ARADDR_I,
  input wire ARVALID_I,
  output reg ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I,
  input wire WR_CLK_I,
  input wire WRITE_STROBE_I,
  input wire [`DATA_W-1:0] WRITE_WORD_I,
  output reg FULL_O,
  output reg ALMOST_FULL_FLAG_O,
  input wire RD_CLK_I,
  input wire READ_STROBE_I,
  output reg [`DATA_W-1:0] READ_WORD_O,
  output reg EMPTY_O,
  output reg ALMOST_EMPTY_FLAG_O,
  output reg IRQ_O
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [31:0] ctrl;
  reg [31:0] thresh;
  reg [`IRQ_W-1:0] irq_stat;
  reg [`IRQ_W-1:0] irq_en;
  reg [`DATA_W-1:0] mem [0:`MEM_WORDS-1];
  reg [`PTR_W-1:0] wptr;
  reg [`PTR_W-1:0] rptr;
  reg [`PTR_W-1:0] wgray;
  reg [`PTR_W-1:0] rgray;
  reg [`DATA_W-1:0] pipe_word;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire wtick;
  wire rtick;
  wire [`DATA_W+1-1:0] wside_s;
  wire rstrobe_s;
  wire [`PTR_W-1:0] rgray_s;
  wire [`PTR_W-1:0] wgray_s;
  wire fifo_clear;
  wire sync_rst;
  wire [2:0] width_code;
  wire [2:0] depth_log;
  wire [4:0] cap_log;
  wire [`PTR_W-1:0] cap;
  wire [`PTR_W-1:0] addr_mask;
  wire [`DATA_W-1:0] word_mask;
  wire [`PTR_W-1:0] wcount;
  wire [`PTR_W-1:0] rcount;
  wire full_now;
  wire empty_now;
  wire next_full;
  wire next_almost_full_flag;
  wire next_empty;
  wire next_almost_empty_flag;
  wire do_write;
  wire do_read;
  wire [`IRQ_W-1:0] events;
  wire [`IRQ_W-1:0] clr_mask;
  wire wr_go;
  reg [31:0] rd_mux;
  reg rd_hit;

  // Gray to binary conversion
  function [`PTR_W-1:0] gray2bin;
    input [`PTR_W-1:0] g;
    integer i;
    begin
      gray2bin[`PTR_W-1] = g[`PTR_W-1];
      for (i = `PTR_W - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // Data width in bits for each width code
  function [`DATA_W-1:0] width_mask;
    input [2:0] code;
    begin
      case (code)
        3'h0: width_mask = 36'h0_0000_0001;
        3'h1: width_mask = 36'h0_0000_0003;
        3'h2: width_mask = 36'h0_0000_000F;
        3'h3: width_mask = 36'h0_0000_01FF;
        3'h4: width_mask = 36'h0_0003_FFFF;
        default: width_mask = 36'hF_FFFF_FFFF;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  assign fifo_clear = ctrl[`CTRL_CLEAR];
  assign sync_rst = RST_I | fifo_clear;
  assign width_code = (ctrl[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO] > `MAX_WIDTH_CODE) ?
                      `MAX_WIDTH_CODE : ctrl[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO];
  assign depth_log = (ctrl[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO] > `MAX_DEPTH_LOG) ?
                     `MAX_DEPTH_LOG : ctrl[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO];
  // Words per block shrink as width grows; cascade count multiplies them
  assign cap_log = `BLOCK_LOG - {2'h0, width_code} + {2'h0, depth_log};
  assign cap = {{(`PTR_W-1){1'b0}}, 1'b1} << cap_log;
  assign addr_mask = cap - {{(`PTR_W-1){1'b0}}, 1'b1};
  assign word_mask = width_mask(width_code);

  // ----------------------------------------
  // Pin capture and clock edge ticks
  // ----------------------------------------
  clock_edge_tick u_wtick (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(WR_CLK_I),
    .falling_i(ctrl[`CTRL_WFALL]),
    .tick_o(wtick)
  );

  clock_edge_tick u_rtick (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(RD_CLK_I),
    .falling_i(ctrl[`CTRL_RFALL]),
    .tick_o(rtick)
  );

  sync_stage #(.W(`DATA_W+1)) u_wside (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i({WRITE_STROBE_I, WRITE_WORD_I}),
    .q_o(wside_s)
  );

  sync_stage #(.W(1)) u_rside (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(READ_STROBE_I),
    .q_o(rstrobe_s)
  );

  // Gray pointers cross into the opposite side
  sync_stage #(.W(`PTR_W)) u_r2w (
    .clk_i(CLK_I),
    .rst_i(sync_rst),
    .d_i(rgray),
    .q_o(rgray_s)
  );

  sync_stage #(.W(`PTR_W)) u_w2r (
    .clk_i(CLK_I),
    .rst_i(sync_rst),
    .d_i(wgray),
    .q_o(wgray_s)
  );

  // ----------------------------------------
  // Occupancy and flag terms
  // ----------------------------------------
  assign wcount = wptr - gray2bin(rgray_s);
  assign rcount = gray2bin(wgray_s) - rptr;
  assign full_now = (wcount >= cap);
  assign empty_now = (rcount == {`PTR_W{1'b0}});
  assign next_full = ~fifo_clear & full_now;
  assign next_almost_full_flag = ~fifo_clear &
                      (wcount + {9'h000, thresh[`TH_AF_HI:`TH_AF_LO]} >= cap);
  assign next_empty = fifo_clear | empty_now;
  assign next_almost_empty_flag = fifo_clear |
                       (rcount <= {9'h000, thresh[`TH_AE_HI:`TH_AE_LO]});
  assign do_write = wtick & wside_s[`DATA_W] & ~full_now & ~fifo_clear;
  assign do_read = rtick & rstrobe_s & ~empty_now & ~fifo_clear;

  // ----------------------------------------
  // Write side: store word, advance pointer
  // ----------------------------------------
  always @(posedge CLK_I) begin
    if (do_write) begin
      mem[wptr[`ADDR_W-1:0] & addr_mask[`ADDR_W-1:0]] <= wside_s[`DATA_W-1:0] & word_mask;
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I || fifo_clear) begin
      wptr <= {`PTR_W{1'b0}};
      wgray <= {`PTR_W{1'b0}};
    end else if (do_write) begin
      wptr <= wptr + {{(`PTR_W-1){1'b0}}, 1'b1};
      wgray <= (wptr + {{(`PTR_W-1){1'b0}}, 1'b1}) ^
               ((wptr + {{(`PTR_W-1){1'b0}}, 1'b1}) >> 1);
    end
  end

  // ----------------------------------------
  // Read side: pointer, direct or piped output
  // ----------------------------------------
  always @(posedge CLK_I) begin
    if (RST_I || fifo_clear) begin
      rptr <= {`PTR_W{1'b0}};
      rgray <= {`PTR_W{1'b0}};
      pipe_word <= {`DATA_W{1'b0}};
      READ_WORD_O <= {`DATA_W{1'b0}};
    end else begin
      if (do_read) begin
        rptr <= rptr + {{(`PTR_W-1){1'b0}}, 1'b1};
        rgray <= (rptr + {{(`PTR_W-1){1'b0}}, 1'b1}) ^
                 ((rptr + {{(`PTR_W-1){1'b0}}, 1'b1}) >> 1);
        pipe_word <= mem[rptr[`ADDR_W-1:0] & addr_mask[`ADDR_W-1:0]];
      end
      if (ctrl[`CTRL_PIPE]) begin
        if (rtick) begin
          READ_WORD_O <= pipe_word;
        end
      end else if (do_read) begin
        READ_WORD_O <= mem[rptr[`ADDR_W-1:0] & addr_mask[`ADDR_W-1:0]];
      end
    end
  end

  // Registered flags
  always @(posedge CLK_I) begin
    if (RST_I) begin
      FULL_O <= 1'b0;
      ALMOST_FULL_FLAG_O <= 1'b0;
      EMPTY_O <= 1'b1;
      ALMOST_EMPTY_FLAG_O <= 1'b1;
    end else begin
      FULL_O <= next_full;
      ALMOST_FULL_FLAG_O <= next_almost_full_flag;
      EMPTY_O <= next_empty;
      ALMOST_EMPTY_FLAG_O <= next_almost_empty_flag;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign events[`IRQ_FULL] = next_full & ~FULL_O;
  assign events[`IRQ_EMPTY] = next_empty & ~EMPTY_O;
  assign events[`IRQ_ALMOST_FULL_FLAG] = next_almost_full_flag & ~ALMOST_FULL_FLAG_O;
  assign events[`IRQ_ALMOST_EMPTY_FLAG] = next_almost_empty_flag & ~ALMOST_EMPTY_FLAG_O;
  assign events[`IRQ_WDROP] = wtick & wside_s[`DATA_W] & full_now;
  assign events[`IRQ_RDROP] = rtick & rstrobe_s & empty_now;
  assign wr_go = aw_held & w_held & ~BVALID_O;
  assign clr_mask = (wr_go && aw_addr == `REG_IRQ_CLR && w_strb[0]) ?
                    w_data[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  // Sticky status; a new event wins over a clear in the same cycle
  always @(posedge CLK_I) begin
    if (RST_I) begin
      irq_stat <= {`IRQ_W{1'b0}};
      IRQ_O <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~clr_mask) | events;
      IRQ_O <= |(((irq_stat & ~clr_mask) | events) & irq_en);
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  always @(posedge CLK_I) begin
    if (RST_I) begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      BVALID_O <= 1'b0;
      BRESP_O <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= `CTRL_RESET;
      thresh <= `THRESH_RESET;
      irq_en <= {`IRQ_W{1'b0}};
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_addr <= AWADDR_I;
        aw_held <= 1'b1;
        AWREADY_O <= 1'b0;
      end
      if (WVALID_I && WREADY_O) begin
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
        w_held <= 1'b1;
        WREADY_O <= 1'b0;
      end
      if (wr_go) begin
        BVALID_O <= 1'b1;
        BRESP_O <= `RESP_OKAY;
        case (aw_addr)
          `REG_CTRL: begin
            if (w_strb[0]) ctrl[7:0] <= w_data[7:0];
            if (w_strb[1]) ctrl[15:8] <= w_data[15:8];
          end
          `REG_THRESH: begin
            if (w_strb[0]) thresh[7:0] <= w_data[7:0];
            if (w_strb[1]) thresh[15:8] <= w_data[15:8];
          end
          `REG_IRQ_EN: begin
            if (w_strb[0]) irq_en <= w_data[`IRQ_W-1:0];
          end
          `REG_IRQ_CLR, `REG_STATUS, `REG_IRQ_STAT: begin
            BRESP_O <= `RESP_OKAY;
          end
          default: begin
            BRESP_O <= `RESP_DECERR;
          end
        endcase
      end
      if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ARADDR_I)
      `REG_CTRL: rd_mux = {21'h000000, ctrl[10:8], 1'b0, ctrl[6:0]};
      `REG_THRESH: rd_mux = {16'h0000, thresh[15:0]};
      `REG_STATUS: begin
        rd_mux[`ST_FULL] = FULL_O;
        rd_mux[`ST_EMPTY] = EMPTY_O;
        rd_mux[`ST_ALMOST_FULL_FLAG] = ALMOST_FULL_FLAG_O;
        rd_mux[`ST_ALMOST_EMPTY_FLAG] = ALMOST_EMPTY_FLAG_O;
        rd_mux[`ST_COUNT_HI:`ST_COUNT_LO] = fifo_clear ? {`PTR_W{1'b0}} : wcount;
      end
      `REG_IRQ_STAT: rd_mux = {26'h0000000, irq_stat};
      `REG_IRQ_EN: rd_mux = {26'h0000000, irq_en};
      `REG_IRQ_CLR: rd_mux = 32'h0000_0000;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= `RESP_OKAY;
    end else begin
      if (ARVALID_I && ARREADY_O) begin
        ARREADY_O <= 1'b0;
        RVALID_O <= 1'b1;
        RDATA_O <= rd_mux;
        RRESP_O <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end
      if (RVALID_O && RREADY_I) begin
        RVALID_O <= 1'b0;
        ARREADY_O <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> bench/fifo_user.sv
// User logic on both FIFO sides: pin clocks, strobes and words.
// Assumes a free-running system clock; pin clocks move only during a transfer.
`timescale 1ns/1ps
`default_nettype none
module fifo_user (
  input wire logic clk_i,
  input wire logic wfall_i,
  input wire logic rfall_i,
  output logic wr_clk_o,
  output logic wr_strobe_o,
  output logic [35:0] wr_word_o,
  output logic rd_clk_o,
  output logic rd_strobe_o
);
  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic wr_lvl = 1'b0;
  logic rd_lvl = 1'b0;
  initial begin
    wr_strobe_o = 1'b0;
    wr_word_o = 36'h0;
    rd_strobe_o = 1'b0;
  end
  // Idle level follows the chosen edge, so raising the level makes the active edge
  assign wr_clk_o = wr_lvl ^ wfall_i;
  assign rd_clk_o = rd_lvl ^ rfall_i;
  // One write clock with word and strobe held four cycles either side
  task automatic push(input logic [35:0] w, input logic s);
    @(posedge clk_i);
    wr_word_o <= w;
    wr_strobe_o <= s;
    repeat (4) @(posedge clk_i);
    wr_lvl <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr_lvl <= 1'b0;
    repeat (4) @(posedge clk_i);
    // Released word shows its inverse, not the last value
    wr_word_o <= ~w;
    wr_strobe_o <= 1'b0;
  endtask
  // One read clock with the strobe held around it
  task automatic pop(input logic s);
    @(posedge clk_i);
    rd_strobe_o <= s;
    repeat (4) @(posedge clk_i);
    rd_lvl <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_lvl <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_strobe_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/fifo_monitor.sv
// Port checker for the FIFO: bus handshakes and flag relations.
// Assumes it is bound onto dual_clock_fifo, one system clock.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defines.vh"
module fifo_monitor (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic [1:0] BRESP_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic FULL_O,
  input wire logic ALMOST_FULL_FLAG_O,
  input wire logic EMPTY_O,
  input wire logic ALMOST_EMPTY_FLAG_O,
  input wire logic IRQ_O
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_flags_excl: assert property (!(FULL_O && EMPTY_O))
    else $error("full and empty set together");
  a_full_almost_full_flag: assert property (FULL_O |-> ALMOST_FULL_FLAG_O)
    else $error("full without almost full");
  a_empty_almost_empty_flag: assert property (EMPTY_O |-> ALMOST_EMPTY_FLAG_O)
    else $error("empty without almost empty");
  a_reset_flags: assert property ($fell(RST_I) |-> EMPTY_O && ALMOST_EMPTY_FLAG_O
    && !FULL_O && !ALMOST_FULL_FLAG_O && !IRQ_O) else $error("flags wrong after reset");
  a_write_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
    |-> ##[1:2] BVALID_O) else $error("write response late");
  a_aw_refused: assert property (AWVALID_I && AWREADY_O |=> !AWREADY_O)
    else $error("second write address accepted");
  a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
    else $error("read answer not in one cycle");
  a_r_release: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read data held after handshake");
  a_b_release: assert property (BVALID_O && BREADY_I |=> !BVALID_O ##[0:1] AWREADY_O)
    else $error("write channel not released");
  a_resp_legal: assert property (BVALID_O |-> BRESP_O == `RESP_OKAY
    || BRESP_O == `RESP_DECERR) else $error("illegal write response");
endmodule
bind dual_clock_fifo fifo_monitor fifo_monitor_i (.CLK_I(CLK_I), .RST_I(RST_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I),
  .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
  .RREADY_I(RREADY_I), .FULL_O(FULL_O), .ALMOST_FULL_FLAG_O(ALMOST_FULL_FLAG_O),
  .EMPTY_O(EMPTY_O), .ALMOST_EMPTY_FLAG_O(ALMOST_EMPTY_FLAG_O), .IRQ_O(IRQ_O));
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the dual-clock FIFO with its register bus.
// Assumes the partner model and the bound port checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defines.vh"
module testbench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] wmask = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic wfall = 1'b0, rfall = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, full, almost_full_flag, empty, almost_empty_flag, irq;
  wire wr_clk, wr_strobe, rd_clk, rd_strobe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [`DATA_W-1:0] wr_word, rd_word;
  int fail_count = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  dual_clock_fifo dual_clock_fifo_i (.CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .WR_CLK_I(wr_clk), .WRITE_STROBE_I(wr_strobe), .WRITE_WORD_I(wr_word),
    .FULL_O(full), .ALMOST_FULL_FLAG_O(almost_full_flag), .RD_CLK_I(rd_clk),
    .READ_STROBE_I(rd_strobe), .READ_WORD_O(rd_word), .EMPTY_O(empty),
    .ALMOST_EMPTY_FLAG_O(almost_empty_flag), .IRQ_O(irq));
  fifo_user fifo_user_i (.clk_i(clk), .wfall_i(wfall), .rfall_i(rfall),
    .wr_clk_o(wr_clk), .wr_strobe_o(wr_strobe), .wr_word_o(wr_word),
    .rd_clk_o(rd_clk), .rd_strobe_o(rd_strobe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare one value and count it
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [35:0] wd(input int i);
    return {i[3:0], ~{4{i[7:0]}}};
  endfunction
  // Write address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= wmask;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge clk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge clk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk($sformatf("reg %h", a), e, rdata);
    chk("rresp", er, rresp);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    axi_rd(`REG_CTRL, `CTRL_RESET, `RESP_OKAY);
    axi_rd(`REG_THRESH, `THRESH_RESET, `RESP_OKAY);
    axi_rd(`REG_STATUS, 32'h0000_000A, `RESP_OKAY);
    axi_rd(`REG_IRQ_STAT, 32'h0, `RESP_OKAY);
    axi_rd(`REG_IRQ_CLR, 32'h0, `RESP_OKAY);
    axi_rd(`REG_IRQ_EN, 32'h0, `RESP_OKAY);
    axi_rd(8'h20, 32'h0, `RESP_DECERR);
    axi_wr(8'h20, 32'hFFFF_FFFF, `RESP_DECERR);
    $display("test reset done");
  endtask
  // Fill 128 words of 36 bits, then one dropped write raises the interrupt
  task automatic t_fill;
    axi_wr(`REG_THRESH, 32'h0000_0204, `RESP_OKAY);
    axi_rd(`REG_THRESH, 32'h0000_0204, `RESP_OKAY);
    axi_wr(`REG_IRQ_EN, 32'h0000_0010, `RESP_OKAY);
    for (int i = 1; i <= 128; i++) begin
      fifo_user_i.push(wd(i - 1), 1'b1);
      chk("full", i >= 128, full);
      chk("almost_full_flag", i + 4 >= 128, almost_full_flag);
    end
    chk("irq masked", 1'b0, irq);
    fifo_user_i.push(wd(200), 1'b1);
    chk("irq drop", 1'b1, irq);
    axi_rd(`REG_STATUS, 32'h0000_0805, `RESP_OKAY);
    axi_rd(`REG_IRQ_STAT, 32'h0000_0015, `RESP_OKAY);
    axi_wr(`REG_IRQ_CLR, 32'h0000_003F, `RESP_OKAY);
    axi_rd(`REG_IRQ_STAT, 32'h0, `RESP_OKAY);
    chk("irq cleared", 1'b0, irq);
    $display("test fill done");
  endtask
  // Drain in order, then a read while empty is refused
  task automatic t_drain;
    axi_wr(`REG_IRQ_EN, 32'h0000_0020, `RESP_OKAY);
    for (int i = 0; i < 128; i++) begin
      fifo_user_i.pop(1'b1);
      chk("word", wd(i), rd_word);
      chk("empty", i == 127, empty);
      chk("almost_empty_flag", 127 - i <= 2, almost_empty_flag);
    end
    chk("irq masked", 1'b0, irq);
    fifo_user_i.pop(1'b1);
    chk("word kept", wd(127), rd_word);
    chk("irq drop", 1'b1, irq);
    axi_rd(`REG_IRQ_STAT, 32'h0000_002A, `RESP_OKAY);
    axi_wr(`REG_IRQ_CLR, 32'h0000_003F, `RESP_OKAY);
    $display("test drain done");
  endtask
  // Narrow width on falling edges, pipelined output, then clear
  task automatic t_modes;
    axi_wr(`REG_CTRL, 32'h0000_000D, `RESP_OKAY);
    wfall <= 1'b1;
    rfall <= 1'b1;
    axi_wr(`REG_CTRL, 32'h0000_000C, `RESP_OKAY);
    fifo_user_i.push(36'hF_FFFF_FFFF, 1'b1);
    fifo_user_i.push(36'h0_0000_0002, 1'b1);
    fifo_user_i.pop(1'b1);
    chk("narrow0", 36'h1, rd_word);
    fifo_user_i.pop(1'b1);
    chk("narrow1", 36'h0, rd_word);
    axi_wr(`REG_CTRL, 32'h0000_0053, `RESP_OKAY);
    wfall <= 1'b0;
    rfall <= 1'b0;
    axi_wr(`REG_CTRL, 32'h0000_0052, `RESP_OKAY);
    fifo_user_i.push(wd(5), 1'b1);
    fifo_user_i.push(wd(6), 1'b1);
    fifo_user_i.pop(1'b1);
    chk("pipe lag", 36'h0, rd_word);
    fifo_user_i.pop(1'b1);
    chk("pipe a", wd(5), rd_word);
    fifo_user_i.pop(1'b0);
    chk("pipe b", wd(6), rd_word);
    fifo_user_i.push(wd(7), 1'b1);
    axi_wr(`REG_CTRL, 32'h0000_0053, `RESP_OKAY);
    repeat (8) @(posedge clk);
    chk("clr flags", 4'b0011, {full, almost_full_flag, empty, almost_empty_flag});
    chk("clr word", 36'h0, rd_word);
    $display("test modes done");
  endtask
  // Two cascaded blocks, a byte-0 strobe only, and a write with its strobe low
  task automatic t_depth;
    axi_wr(`REG_CTRL, 32'h0000_0151, `RESP_OKAY);
    axi_wr(`REG_CTRL, 32'h0000_0150, `RESP_OKAY);
    wmask = 4'h1;
    axi_wr(`REG_THRESH, 32'h0000_FFFE, `RESP_OKAY);
    wmask = 4'hF;
    axi_rd(`REG_THRESH, 32'h0000_02FE, `RESP_OKAY);
    fifo_user_i.push(wd(8), 1'b0);
    chk("strobe low", 1'b1, empty);
    fifo_user_i.push(wd(9), 1'b1);
    chk("almost_full_flag 1 of 256", 1'b0, almost_full_flag);
    fifo_user_i.push(wd(10), 1'b1);
    chk("almost_full_flag 2 of 256", 1'b1, almost_full_flag);
    fifo_user_i.pop(1'b1);
    chk("depth word", wd(9), rd_word);
    $display("test depth done");
  endtask
  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    t_fill;
    t_drain;
    t_modes;
    t_depth;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize;
  end
endmodule
`default_nettype wire
